// ==== hdl/rtom_consts.vh ====
/*
  Constants for the receive transport overhead monitor: register indices,
  field positions, reset values, framing bytes and overhead byte positions.
  Assumes an STM-0 frame of 9 rows with 3 overhead columns per row.
*/
`ifndef RTOM_CONSTS_VH
`define RTOM_CONSTS_VH

// Register indices; byte address is four times the index
`define RTOM_IDX_CTRL_HI 10'h202
`define RTOM_IDX_CTRL_LO 10'h203
`define RTOM_IDX_DEFECT 10'h206
`define RTOM_IDX_B1_CNT 10'h208
`define RTOM_IDX_B2_CNT 10'h209
`define RTOM_IDX_REI_CNT 10'h20A
`define RTOM_IDX_TRACE_EXP 10'h20B
`define RTOM_IDX_THRESH 10'h20C
`define RTOM_IDX_LINK_STAT 10'h20D
`define RTOM_IDX_INT_STAT 10'h20E
`define RTOM_IDX_INT_MASK 10'h20F

// Control high fields
`define RTOM_HI_OH_OFF 0
`define RTOM_HI_B1_SYNC 2
// Control low fields
`define RTOM_LO_B1_KIND 0
`define RTOM_LO_B2_KIND 1
`define RTOM_LO_REI_KIND 2
`define RTOM_LO_STD_SEL 3
`define RTOM_LO_DSCR_OFF 4
`define RTOM_LO_SD_EN 5
`define RTOM_LO_SF_EN 6
// Defect status fields
`define RTOM_DS_AIS 0
`define RTOM_DS_UNSTABLE 1
`define RTOM_DS_MISMATCH 2
// Interrupt status fields
`define RTOM_IRQ_W 6
`define RTOM_IRQ_SYNC 0
`define RTOM_IRQ_AIS 1
`define RTOM_IRQ_UNSTABLE 2
`define RTOM_IRQ_MISMATCH 3
`define RTOM_IRQ_SF 4
`define RTOM_IRQ_SD 5

`define RTOM_CTRL_RST 8'h00
`define RTOM_TRACE_EXP_RST 8'h00
`define RTOM_THRESH_RST 32'h0000_0000

// Framing and overhead layout
`define RTOM_A1 8'hF6
`define RTOM_A2 8'h28
`define RTOM_ROWS 4'h9
`define RTOM_TOH_COLS 7'h03
`define RTOM_ROW_B1 4'h1
`define RTOM_ROW_B2 4'h4
`define RTOM_ROW_REI 4'h8
`define RTOM_COL_J0 7'h02
`define RTOM_COL_K2 7'h02
`define RTOM_COL_REI 7'h01
`define RTOM_SCR_SEED 7'h7F
`define RTOM_B1_GOOD_NEED 2'h2
`define RTOM_AIS_FRAMES 3'h5
`define RTOM_AIS_CODE 3'h7
`define RTOM_UNSTABLE_LIMIT 4'h8

`endif

// ==== hdl/rtom_monitor.v ====
/*
  Receive transport overhead monitor: frames on A1/A2 (optionally B1
  qualified), descrambles, extracts overhead, counts B1/B2/REI-L errors,
  gates SF/SD, reports trace, unstable and AIS-L defects over APB.
  Assumes line bytes arrive synchronous to mclk_i with a valid strobe,
  and a single 25 MHz clock domain.
*/
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "rtom_consts.vh"

// Contract
// (R1) With B1 qualify set, sync needs two consecutive good B1 after A1/A2.
// (R2) Overhead extraction runs by default; setting the off bit stops it.
// (R3) SF is neither declared nor cleared unless SF detect is enabled.
// (R4) SD is neither declared nor cleared unless SD detect is enabled.
// (R5) Descramble unless descramble disable is set.
// (R6) Standard select bit: 0 SONET, 1 SDH processing.
// (R7) Per-bit REI-L mode adds M0/M1 lower nibble value to the counter.
// (R8) Per-frame REI-L mode adds one per frame with non-zero nibble.
// (R9) Per-bit B2 mode adds the number of errored B2 bits.
// (R10) Per-frame B2 mode adds one per frame with errored B2.
// (R11) Per-bit B1 mode adds the number of errored B1 bits.
// (R12) Per-frame B1 mode adds one per frame with errored B1.
// (R13) Trace mismatch flags when the accepted J0 differs from expected.
// (R14) Unstable counter counts mismatches, declares at 8, clears on persistence.
// (R15) AIS-L declared after five consecutive frames with K2 low bits 111.
// (R16) Defect status read is live, side-effect free, unused bits zero.
module rtom_monitor #(
  parameter COLS = 90,
  parameter CNT_W = 16,
  parameter TRACE_PERSIST = 3,
  parameter SFSD_WIN = 8000
) (
  input wire mclk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output reg pslverr_o,
  input wire [7:0] line_data_i,
  input wire line_valid_i,
  output reg [7:0] rx_data_o,
  output reg rx_valid_o,
  output reg [7:0] toh_data_o,
  output reg [3:0] toh_row_o,
  output reg [6:0] toh_col_o,
  output reg toh_valid_o,
  output reg in_sync_o,
  output wire std_sdh_o,
  output wire irq_o
);

  localparam ST_HUNT = 2'b00;
  localparam ST_PRE = 2'b01;
  localparam ST_SYNC = 2'b10;
  localparam [31:0] LAST_COL_W = COLS - 1;
  localparam [6:0] LAST_COL = LAST_COL_W[6:0];
  localparam [31:0] WIN_LAST_W = SFSD_WIN - 1;

  function [3:0] ones8;
    input [7:0] v;
    integer k;
    begin
      ones8 = 4'h0;
      for (k = 0; k < 8; k = k + 1)
        ones8 = ones8 + {3'b000, v[k]};
    end
  endfunction

  // Frame synchronous x^7+x^6+1 keystream, MSB first; returns {state, key}
  function [14:0] scr_step;
    input [6:0] s;
    integer k;
    reg [6:0] t;
    reg [7:0] key;
    begin
      t = s;
      key = 8'h00;
      for (k = 7; k >= 0; k = k - 1) begin
        key[k] = t[6];
        t = {t[5:0], t[6] ^ t[5]};
      end
      scr_step = {t, key};
    end
  endfunction

  // =======================================================
  // Registers and bus
  // =======================================================
  reg [7:0] ctrl_hi_r, ctrl_lo_r, trace_exp_r;
  reg [31:0] thresh_r;
  reg [`RTOM_IRQ_W-1:0] int_stat_r, int_mask_r;
  reg [CNT_W-1:0] b1_cnt_r, b2_cnt_r, rei_cnt_r;
  reg ais_r, unstable_r, mismatch_r, sf_r, sd_r;
  reg [31:0] rdata_nxt;
  reg map_hit;

  wire [9:0] idx = paddr_i[11:2];
  wire setup = psel_i & ~penable_i;
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i & ~pslverr_o;
  wire rd = acc & ~pwrite_i & ~pslverr_o;
  wire rd_b1 = rd & (idx == `RTOM_IDX_B1_CNT);
  wire rd_b2 = rd & (idx == `RTOM_IDX_B2_CNT);
  wire rd_rei = rd & (idx == `RTOM_IDX_REI_CNT);
  wire rd_int = rd & (idx == `RTOM_IDX_INT_STAT);
  wire [7:0] defect_view = {5'h00, mismatch_r, unstable_r, ais_r};

  assign pready_o = acc;
  assign std_sdh_o = ctrl_lo_r[`RTOM_LO_STD_SEL]; // R6
  assign irq_o = |(int_stat_r & int_mask_r);

  always @* begin
    rdata_nxt = 32'h0000_0000;
    map_hit = 1'b1;
    case (idx)
      `RTOM_IDX_CTRL_HI: rdata_nxt[7:0] = ctrl_hi_r;
      `RTOM_IDX_CTRL_LO: rdata_nxt[7:0] = ctrl_lo_r;
      `RTOM_IDX_DEFECT: rdata_nxt[7:0] = defect_view; // R16
      `RTOM_IDX_B1_CNT: rdata_nxt[CNT_W-1:0] = b1_cnt_r;
      `RTOM_IDX_B2_CNT: rdata_nxt[CNT_W-1:0] = b2_cnt_r;
      `RTOM_IDX_REI_CNT: rdata_nxt[CNT_W-1:0] = rei_cnt_r;
      `RTOM_IDX_TRACE_EXP: rdata_nxt[7:0] = trace_exp_r;
      `RTOM_IDX_THRESH: rdata_nxt = thresh_r;
      `RTOM_IDX_LINK_STAT: rdata_nxt[2:0] = {sd_r, sf_r, in_sync_o};
      `RTOM_IDX_INT_STAT: rdata_nxt[`RTOM_IRQ_W-1:0] = int_stat_r;
      `RTOM_IDX_INT_MASK: rdata_nxt[`RTOM_IRQ_W-1:0] = int_mask_r;
      default: map_hit = 1'b0;
    endcase
    if (paddr_i[1:0] != 2'b00)
      map_hit = 1'b0;
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      ctrl_hi_r <= `RTOM_CTRL_RST;
      ctrl_lo_r <= `RTOM_CTRL_RST;
      trace_exp_r <= `RTOM_TRACE_EXP_RST;
      thresh_r <= `RTOM_THRESH_RST;
      int_mask_r <= {`RTOM_IRQ_W{1'b0}};
    end else begin
      if (setup) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_nxt;
        pslverr_o <= ~map_hit;
      end
      if (wr) begin
        case (idx)
          `RTOM_IDX_CTRL_HI: begin
            ctrl_hi_r[`RTOM_HI_OH_OFF] <= pwdata_i[`RTOM_HI_OH_OFF];
            ctrl_hi_r[`RTOM_HI_B1_SYNC] <= pwdata_i[`RTOM_HI_B1_SYNC];
          end
          `RTOM_IDX_CTRL_LO: ctrl_lo_r <= {1'b0, pwdata_i[6:0]};
          `RTOM_IDX_TRACE_EXP: trace_exp_r <= pwdata_i[7:0];
          `RTOM_IDX_THRESH: thresh_r <= pwdata_i;
          `RTOM_IDX_INT_MASK: int_mask_r <= pwdata_i[`RTOM_IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // =======================================================
  // Framing, descrambling and position
  // =======================================================
  reg [1:0] fstate_r;
  reg a1_seen_r;
  reg [3:0] row_r;
  reg [6:0] col_r;
  reg [6:0] scr_r;
  reg [1:0] b1_good_r;
  reg [7:0] b1_acc_r, b2_acc_r, b1_exp_r, b2_exp_r;

  wire b1_qual = ctrl_hi_r[`RTOM_HI_B1_SYNC];
  wire in_toh = (col_r < `RTOM_TOH_COLS);
  wire unscr = (row_r == 4'h0) & in_toh;
  wire [14:0] scr_out = scr_step(scr_r);
  wire dscr_on = ~ctrl_lo_r[`RTOM_LO_DSCR_OFF] & ~unscr; // R5
  wire [7:0] dbyte = dscr_on ? (line_data_i ^ scr_out[7:0]) : line_data_i;
  wire framed = (fstate_r != ST_HUNT);
  wire last_byte = (row_r == `RTOM_ROWS - 4'h1) & (col_r == LAST_COL);
  wire at_a1 = (row_r == 4'h0) & (col_r == 7'h00);
  wire at_a2 = (row_r == 4'h0) & (col_r == 7'h01);
  wire at_b1 = (row_r == `RTOM_ROW_B1) & (col_r == 7'h00);
  wire at_b2 = (row_r == `RTOM_ROW_B2) & (col_r == 7'h00);
  wire at_k2 = (row_r == `RTOM_ROW_B2) & (col_r == `RTOM_COL_K2);
  wire at_j0 = (row_r == 4'h0) & (col_r == `RTOM_COL_J0);
  wire at_rei = (row_r == `RTOM_ROW_REI) & (col_r == `RTOM_COL_REI);
  wire rsoh = (row_r < 4'h3) & in_toh;
  wire [7:0] b1_diff = dbyte ^ b1_exp_r;
  wire [7:0] b2_diff = dbyte ^ b2_exp_r;
  wire b1_bad = |b1_diff;
  wire step = line_valid_i & framed;
  wire sync_ok = step & (fstate_r == ST_SYNC);

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fstate_r <= ST_HUNT;
      a1_seen_r <= 1'b0;
      row_r <= 4'h0;
      col_r <= 7'h00;
      scr_r <= `RTOM_SCR_SEED;
      b1_good_r <= 2'b00;
      b1_acc_r <= 8'h00;
      b2_acc_r <= 8'h00;
      b1_exp_r <= 8'h00;
      b2_exp_r <= 8'h00;
    end else if (line_valid_i) begin
      if (!framed) begin
        a1_seen_r <= (line_data_i == `RTOM_A1);
        if (a1_seen_r && line_data_i == `RTOM_A2) begin
          fstate_r <= ST_PRE;
          row_r <= 4'h0;
          col_r <= `RTOM_COL_J0;
          b1_good_r <= 2'b00;
          b1_acc_r <= `RTOM_A1 ^ `RTOM_A2;
        end
      end else begin
        col_r <= (col_r == LAST_COL) ? 7'h00 : col_r + 7'h01;
        if (col_r == LAST_COL)
          row_r <= last_byte ? 4'h0 : row_r + 4'h1;
        scr_r <= (row_r == 4'h0 && col_r == `RTOM_COL_J0) ? `RTOM_SCR_SEED : scr_out[14:8];
        // B1 covers raw bytes, B2 descrambled bytes outside the RSOH
        b1_acc_r <= last_byte ? 8'h00 : (b1_acc_r ^ line_data_i);
        b2_acc_r <= last_byte ? 8'h00 : (rsoh ? b2_acc_r : (b2_acc_r ^ dbyte));
        if (last_byte) begin
          b1_exp_r <= b1_acc_r ^ line_data_i;
          b2_exp_r <= b2_acc_r ^ dbyte;
        end
        if ((at_a1 && line_data_i != `RTOM_A1) || (at_a2 && line_data_i != `RTOM_A2)) begin
          fstate_r <= ST_HUNT;
          a1_seen_r <= 1'b0;
        end else if (at_a2 && fstate_r == ST_PRE) begin
          if (!b1_qual || b1_good_r == `RTOM_B1_GOOD_NEED)
            fstate_r <= ST_SYNC; // R1
        end
        if (at_b1 && fstate_r == ST_PRE) begin
          if (b1_bad)
            b1_good_r <= 2'b00; // R1
          else if (b1_good_r != `RTOM_B1_GOOD_NEED)
            b1_good_r <= b1_good_r + 2'b01; // R1
        end
      end
    end
  end

  // =======================================================
  // Stream and overhead outputs
  // =======================================================
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
      toh_data_o <= 8'h00;
      toh_row_o <= 4'h0;
      toh_col_o <= 7'h00;
      toh_valid_o <= 1'b0;
      in_sync_o <= 1'b0;
    end else begin
      in_sync_o <= (fstate_r == ST_SYNC);
      rx_valid_o <= sync_ok;
      toh_valid_o <= sync_ok & in_toh & ~ctrl_hi_r[`RTOM_HI_OH_OFF]; // R2
      if (sync_ok) begin
        rx_data_o <= dbyte;
        toh_row_o <= row_r;
        toh_col_o <= col_r;
        if (in_toh && !ctrl_hi_r[`RTOM_HI_OH_OFF])
          toh_data_o <= dbyte; // R2
      end
    end
  end

  // =======================================================
  // Error counters; a read clears, a same-cycle event is kept
  // =======================================================
  wire [3:0] b1_ones = ones8(b1_diff);
  wire [3:0] b2_ones = ones8(b2_diff);
  wire [3:0] b1_inc = ctrl_lo_r[`RTOM_LO_B1_KIND] ? {3'b000, b1_bad} : b1_ones; // R11 R12
  wire [3:0] b2_inc = ctrl_lo_r[`RTOM_LO_B2_KIND] ? {3'b000, |b2_diff} : b2_ones; // R9 R10
  wire [3:0] rei_inc = ctrl_lo_r[`RTOM_LO_REI_KIND] ? {3'b000, |dbyte[3:0]} : dbyte[3:0]; // R7 R8
  wire [3:0] b1_add = (sync_ok & at_b1) ? b1_inc : 4'h0;
  wire [3:0] b2_add = (sync_ok & at_b2) ? b2_inc : 4'h0;
  wire [3:0] rei_add = (sync_ok & at_rei) ? rei_inc : 4'h0;

  reg [CNT_W-1:0] win_cnt_r;
  reg [CNT_W-1:0] win_err_r;
  wire win_end = sync_ok & last_byte & (win_cnt_r == WIN_LAST_W[CNT_W-1:0]);
  wire [CNT_W-1:0] win_sum = win_err_r + {{(CNT_W-4){1'b0}}, b2_ones & {4{sync_ok & at_b2}}};

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      b1_cnt_r <= {CNT_W{1'b0}};
      b2_cnt_r <= {CNT_W{1'b0}};
      rei_cnt_r <= {CNT_W{1'b0}};
      win_cnt_r <= {CNT_W{1'b0}};
      win_err_r <= {CNT_W{1'b0}};
      sf_r <= 1'b0;
      sd_r <= 1'b0;
    end else begin
      b1_cnt_r <= (rd_b1 ? {CNT_W{1'b0}} : b1_cnt_r) + {{(CNT_W-4){1'b0}}, b1_add};
      b2_cnt_r <= (rd_b2 ? {CNT_W{1'b0}} : b2_cnt_r) + {{(CNT_W-4){1'b0}}, b2_add};
      rei_cnt_r <= (rd_rei ? {CNT_W{1'b0}} : rei_cnt_r) + {{(CNT_W-4){1'b0}}, rei_add};
      if (sync_ok && last_byte)
        win_cnt_r <= win_end ? {CNT_W{1'b0}} : win_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      win_err_r <= win_end ? {CNT_W{1'b0}} : win_sum;
      if (win_end && ctrl_lo_r[`RTOM_LO_SF_EN])
        sf_r <= (win_sum > thresh_r[15:0]); // R3
      if (win_end && ctrl_lo_r[`RTOM_LO_SD_EN])
        sd_r <= (win_sum > thresh_r[31:16]); // R4
    end
  end

  // =======================================================
  // Trace and AIS-L defects
  // =======================================================
  reg [7:0] j0_last_r, j0_acc_r;
  reg [2:0] j0_same_r;
  reg [3:0] unst_cnt_r;
  reg [2:0] ais_cnt_r;
  reg j0_ok_r;
  localparam [31:0] PERSIST_W = TRACE_PERSIST;
  wire [2:0] persist = PERSIST_W[2:0];
  wire j0_same = (dbyte == j0_last_r);
  wire [2:0] same_nxt = j0_same ? ((j0_same_r == persist) ? persist : j0_same_r + 3'h1) : 3'h1;
  wire k2_ais = (dbyte[2:0] == `RTOM_AIS_CODE);

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      j0_last_r <= 8'h00;
      j0_acc_r <= 8'h00;
      j0_ok_r <= 1'b0;
      j0_same_r <= 3'h0;
      unst_cnt_r <= 4'h0;
      unstable_r <= 1'b0;
      mismatch_r <= 1'b0;
      ais_cnt_r <= 3'h0;
      ais_r <= 1'b0;
    end else begin
      // Held while the accepted message differs, even if a stray J0 arrives
      mismatch_r <= j0_ok_r & (j0_acc_r != trace_exp_r); // R13
      if (sync_ok && at_j0) begin
        j0_last_r <= dbyte;
        j0_same_r <= same_nxt;
        if (same_nxt == persist) begin
          j0_acc_r <= dbyte; // R13
          j0_ok_r <= 1'b1; // R13
          unst_cnt_r <= 4'h0; // R14
          unstable_r <= 1'b0; // R14
        end else if (dbyte != trace_exp_r) begin
          if (unst_cnt_r != `RTOM_UNSTABLE_LIMIT)
            unst_cnt_r <= unst_cnt_r + 4'h1; // R14
          if (unst_cnt_r == `RTOM_UNSTABLE_LIMIT - 4'h1)
            unstable_r <= 1'b1; // R14
        end
      end
      // Clearing takes five clean frames too, to avoid chatter
      if (sync_ok && at_k2) begin
        if (k2_ais == ais_r)
          ais_cnt_r <= 3'h0;
        else if (ais_cnt_r == `RTOM_AIS_FRAMES - 3'h1) begin
          ais_cnt_r <= 3'h0;
          ais_r <= k2_ais; // R15
        end else
          ais_cnt_r <= ais_cnt_r + 3'h1; // R15
      end
    end
  end

  // =======================================================
  // Interrupt status: any change of a state, set wins over read clear
  // =======================================================
  reg [`RTOM_IRQ_W-1:0] ev_prev_r;
  wire [`RTOM_IRQ_W-1:0] ev_now = {sd_r, sf_r, mismatch_r, unstable_r, ais_r, in_sync_o};

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_prev_r <= {`RTOM_IRQ_W{1'b0}};
      int_stat_r <= {`RTOM_IRQ_W{1'b0}};
    end else begin
      ev_prev_r <= ev_now;
      int_stat_r <= (rd_int ? {`RTOM_IRQ_W{1'b0}} : int_stat_r) | (ev_now ^ ev_prev_r);
    end
  end

endmodule // rtom_monitor

// ==== tb/rtom_asserts.sv ====
/*
  Checker for rtom_monitor: APB timing, register reads and line-side relations.
  Assumes it is bound to the monitor and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "rtom_consts.vh"
module rtom_asserts (
  input wire mclk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire line_valid_i,
  input wire rx_valid_o,
  input wire [6:0] toh_col_o,
  input wire toh_valid_o,
  input wire in_sync_o,
  input wire std_sdh_o,
  input wire irq_o
);
  // ======================================
  // Shadow of the extraction-off bit
  wire acc_w = psel_i && penable_i;
  wire setup_w = psel_i && !penable_i;
  reg oh_off_r;
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      oh_off_r <= 1'b0;
    end else if (acc_w && pwrite_i && paddr_i == {`RTOM_IDX_CTRL_HI, 2'b00}) begin
      oh_off_r <= pwdata_i[0];
    end
  end
  // ======================================
  // Properties
  default clocking dc @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  AST_PREADY: assert property (pready_o == acc_w)
    else $error("pready not tied to the access phase");
  AST_SLVERR: assert property (setup_w && paddr_i[1:0] != 2'b00 |=> pslverr_o)
    else $error("misaligned access not refused");
  AST_PRDATA_HOLD: assert property (acc_w |=> $stable(prdata_o))
    else $error("read data moved at the access edge");
  AST_DEFECT_ZERO: assert property (setup_w && !pwrite_i &&
    paddr_i == {`RTOM_IDX_DEFECT, 2'b00} |=> prdata_o[31:3] == 29'h0)
    else $error("unused defect bits not zero");
  AST_STD_SEL: assert property (acc_w && pwrite_i &&
    paddr_i == {`RTOM_IDX_CTRL_LO, 2'b00} |=> std_sdh_o == $past(pwdata_i[3]))
    else $error("standard select not following write");
  AST_OH_OFF: assert property (oh_off_r && $past(oh_off_r) |-> !toh_valid_o)
    else $error("overhead byte while extraction off");
  AST_RX_LAT: assert property (rx_valid_o |-> $past(line_valid_i))
    else $error("output byte without input byte");
  AST_TOH_COL: assert property (toh_valid_o |-> toh_col_o < 7'h03 && $past(line_valid_i))
    else $error("overhead byte outside overhead columns");
  cover property ($rose(in_sync_o));
  cover property (toh_valid_o);
  cover property ($rose(irq_o));
  cover property (acc_w && pslverr_o);
endmodule // rtom_asserts

// ==== tb/rtom_line_model.sv ====
/*
  Line model: frames of 9 rows by COLS bytes with framing, trace, parity,
  K2 and M1 bytes, optionally scrambled. Assumes inputs change only while
  run_i is low and that runs are whole frames.
*/
`timescale 1ns/1ps
module rtom_line_model #(
  parameter COLS = 4
) (
  input wire mclk_i,
  input wire rst_i,
  input wire run_i,
  input wire scr_on_i,
  input wire a1_bad_i,
  input wire [7:0] j0_i,
  input wire [7:0] b1_err_i,
  input wire [7:0] b2_err_i,
  input wire [7:0] m1_i,
  input wire [7:0] k2_i,
  output reg [7:0] line_data_o = 8'h00,
  output reg [7:0] plain_o = 8'h00,
  output reg line_valid_o = 1'b0
);
  // ======================================
  // Frame generator
  localparam [6:0] LAST = COLS - 1;
  reg [3:0] row_r;
  reg [6:0] col_r;
  reg [6:0] scr_r;
  reg [7:0] acc1_r, last1_r, acc2_r, last2_r;
  reg [7:0] p, s, raw;
  reg [6:0] sv;
  integer i;
  wire top_w = row_r == 4'h0 && col_r < 7'h03;
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {row_r, col_r, acc1_r, last1_r, acc2_r, last2_r} <= 43'h0;
      scr_r <= 7'h7F;
      line_valid_o <= 1'b0;
    end else if (!run_i) begin
      // Idle line toggles so a stale byte is never mistaken for data
      line_valid_o <= 1'b0;
      line_data_o <= ~line_data_o;
    end else begin
      p = 8'h5A ^ {row_r, col_r[3:0]};
      if (top_w) p = col_r == 7'h00 ? (a1_bad_i ? 8'h00 : 8'hF6) : (col_r == 7'h01 ? 8'h28 : j0_i);
      if (row_r == 4'h1 && col_r == 7'h00) p = last1_r ^ b1_err_i;
      if (row_r == 4'h4 && col_r == 7'h00) p = last2_r ^ b2_err_i;
      if (row_r == 4'h4 && col_r == 7'h02) p = k2_i;
      if (row_r == 4'h8 && col_r == 7'h01) p = m1_i;
      sv = (row_r == 4'h0 && col_r == 7'h03) ? 7'h7F : scr_r;
      for (i = 7; i >= 0; i = i - 1) begin
        s[i] = sv[6];
        sv = {sv[5:0], sv[6] ^ sv[5]};
      end
      raw = (top_w || !scr_on_i) ? p : p ^ s;
      scr_r <= sv;
      line_data_o <= raw;
      plain_o <= p;
      line_valid_o <= 1'b1;
      if (row_r == 4'h0 && col_r == 7'h00) begin
        last1_r <= acc1_r;
        acc1_r <= raw;
        last2_r <= acc2_r;
        acc2_r <= 8'h00;
      end else begin
        acc1_r <= acc1_r ^ raw;
        if (row_r > 4'h2 || col_r > 7'h02) acc2_r <= acc2_r ^ p;
      end
      col_r <= col_r == LAST ? 7'h00 : col_r + 7'h01;
      if (col_r == LAST) row_r <= row_r == 4'h8 ? 4'h0 : row_r + 4'h1;
    end
  end
endmodule // rtom_line_model

// ==== tb/rx_transport_overhead_monitor_test.sv ====
/*
  Testbench for rtom_monitor: APB tasks, line model traffic, checks of
  framing, counters, defects and extraction. Assumes the line model and checker.
*/
`timescale 1ns/1ps
`include "rtom_consts.vh"
module rx_transport_overhead_monitor_test;
  localparam COLS = 4;
  localparam FB = 9 * COLS;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, perr, lval, rxv, tohv, insync, sdh, irq;
  logic run = 1'b0, scr = 1'b0, a1bad = 1'b0;
  logic [1:0] mis = 2'b00;
  logic [7:0] ldata, plain, plain_d, rxd, tohd;
  logic [7:0] j0 = 8'h00, b1e = 8'h00, b2e = 8'h00, m1 = 8'h00, k2 = 8'h00;
  int n_fail = 0, check_count = 0, toh_n = 0;
  rtom_monitor #(.COLS(COLS), .SFSD_WIN(2)) dut (.mclk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .line_data_i(ldata), .line_valid_i(lval),
    .rx_data_o(rxd), .rx_valid_o(rxv), .toh_data_o(tohd), .toh_row_o(), .toh_col_o(),
    .toh_valid_o(tohv), .in_sync_o(insync), .std_sdh_o(sdh), .irq_o(irq));
  rtom_line_model #(.COLS(COLS)) far (.mclk_i(clk), .rst_i(rst), .run_i(run), .scr_on_i(scr),
    .a1_bad_i(a1bad), .j0_i(j0), .b1_err_i(b1e), .b2_err_i(b2e), .m1_i(m1), .k2_i(k2),
    .line_data_o(ldata), .plain_o(plain), .line_valid_o(lval));
  initial begin
    forever #20 clk = ~clk;
  end
  // ======================================
  // Shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [9:0] ix, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= {ix, mis};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    if (n >= 16) begin
      n_fail++;
      print_verdict;
    end
  endtask
  task rdchk(input logic [9:0] ix, input logic [31:0] exp);
    apb(1'b0, ix, 32'h0);
    chk(rd, exp);
  endtask
  task frames(input int n);
    toh_n = 0;
    run <= 1'b1;
    repeat (n * FB) @(posedge clk);
    run <= 1'b0;
    // Lets the last byte's one-cycle results land
    repeat (4) @(posedge clk);
  endtask
  always @(posedge clk) begin
    plain_d <= plain;
    if (rxv === 1'b1) chk({24'h0, rxd}, {24'h0, plain_d});
    if (tohv === 1'b1) toh_n <= toh_n + 1;
    if (tohv === 1'b1) chk({24'h0, tohd}, {24'h0, plain_d});
  end
  // ======================================
  // Scenarios
  task t_regs;
    rdchk(`RTOM_IDX_CTRL_HI, 32'h0);
    rdchk(`RTOM_IDX_DEFECT, 32'h0);
    apb(1'b1, `RTOM_IDX_CTRL_HI, 32'hFF);
    rdchk(`RTOM_IDX_CTRL_HI, 32'h5);
    apb(1'b1, `RTOM_IDX_CTRL_LO, 32'hFF);
    rdchk(`RTOM_IDX_CTRL_LO, 32'h7F);
    chk({31'h0, sdh}, 32'h1);
    apb(1'b1, `RTOM_IDX_CTRL_HI, 32'h0);
    apb(1'b1, `RTOM_IDX_CTRL_LO, 32'h0);
    chk({31'h0, sdh}, 32'h0);
    rdchk(10'h3FF, 32'h0);
    chk({31'h0, perr}, 32'h1);
    // Misaligned write must be refused and leave the register alone
    mis = 2'b10;
    apb(1'b1, `RTOM_IDX_CTRL_LO, 32'hFF);
    mis = 2'b00;
    chk({31'h0, perr}, 32'h1);
    rdchk(`RTOM_IDX_CTRL_LO, 32'h0);
    $display("test regs done");
  endtask
  task t_sync;
    scr <= 1'b1;
    frames(3);
    chk({31'h0, insync}, 32'h1);
    apb(1'b1, `RTOM_IDX_CTRL_LO, 32'h10);
    scr <= 1'b0;
    frames(1);
    chk({31'h0, insync}, 32'h1);
    frames(1);
    chk(toh_n, 27);
    apb(1'b1, `RTOM_IDX_CTRL_HI, 32'h1);
    frames(1);
    chk(toh_n, 0);
    apb(1'b1, `RTOM_IDX_CTRL_HI, 32'h0);
    $display("test sync and extraction done");
  endtask
  task t_count;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `RTOM_IDX_CTRL_LO, k ? 32'h17 : 32'h10);
      apb(1'b0, `RTOM_IDX_B1_CNT, 32'h0);
      apb(1'b0, `RTOM_IDX_B2_CNT, 32'h0);
      apb(1'b0, `RTOM_IDX_REI_CNT, 32'h0);
      b1e <= 8'h03;
      b2e <= 8'h07;
      m1 <= 8'hA5;
      frames(2);
      b1e <= 8'h00;
      b2e <= 8'h00;
      m1 <= 8'h00;
      rdchk(`RTOM_IDX_B1_CNT, k ? 32'h2 : 32'h4);
      rdchk(`RTOM_IDX_B2_CNT, k ? 32'h2 : 32'h6);
      rdchk(`RTOM_IDX_REI_CNT, k ? 32'h2 : 32'hA);
    end
    $display("test counters done");
  endtask
  task t_qual;
    a1bad <= 1'b1;
    frames(1);
    a1bad <= 1'b0;
    chk({31'h0, insync}, 32'h0);
    apb(1'b1, `RTOM_IDX_CTRL_HI, 32'h4);
    b1e <= 8'h01;
    frames(4);
    chk({31'h0, insync}, 32'h0);
    b1e <= 8'h00;
    frames(4);
    chk({31'h0, insync}, 32'h1);
    apb(1'b1, `RTOM_IDX_CTRL_HI, 32'h0);
    $display("test qualified sync done");
  endtask
  task t_trace;
    apb(1'b1, `RTOM_IDX_INT_MASK, 32'h8);
    apb(1'b0, `RTOM_IDX_INT_STAT, 32'h0);
    for (int i = 0; i < 9; i++) begin
      j0 <= i[0] ? 8'hC3 : 8'h3C;
      frames(1);
    end
    rdchk(`RTOM_IDX_DEFECT, 32'h2);
    rdchk(`RTOM_IDX_DEFECT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    j0 <= 8'h3C;
    frames(3);
    rdchk(`RTOM_IDX_DEFECT, 32'h4);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `RTOM_IDX_INT_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `RTOM_IDX_TRACE_EXP, 32'h3C);
    rdchk(`RTOM_IDX_DEFECT, 32'h0);
    $display("test trace done");
  endtask
  task t_ais;
    k2 <= 8'h07;
    frames(4);
    rdchk(`RTOM_IDX_DEFECT, 32'h0);
    frames(1);
    rdchk(`RTOM_IDX_DEFECT, 32'h1);
    k2 <= 8'h00;
    frames(5);
    rdchk(`RTOM_IDX_DEFECT, 32'h0);
    $display("test line alarm done");
  endtask
  task t_sfsd;
    b2e <= 8'h01;
    frames(4);
    rdchk(`RTOM_IDX_LINK_STAT, 32'h1);
    apb(1'b1, `RTOM_IDX_CTRL_LO, 32'h50);
    frames(4);
    rdchk(`RTOM_IDX_LINK_STAT, 32'h3);
    apb(1'b1, `RTOM_IDX_CTRL_LO, 32'h30);
    frames(4);
    rdchk(`RTOM_IDX_LINK_STAT, 32'h7);
    b2e <= 8'h00;
    apb(1'b1, `RTOM_IDX_CTRL_LO, 32'h10);
    frames(4);
    rdchk(`RTOM_IDX_LINK_STAT, 32'h7);
    apb(1'b1, `RTOM_IDX_CTRL_LO, 32'h70);
    frames(4);
    rdchk(`RTOM_IDX_LINK_STAT, 32'h1);
    $display("test fail and degrade done");
  endtask
  // ======================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_sync;
    t_count;
    t_qual;
    t_trace;
    t_ais;
    t_sfsd;
    print_verdict;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule // rx_transport_overhead_monitor_test
bind rtom_monitor rtom_asserts u_asrt (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .line_valid_i, .rx_valid_o,
  .toh_col_o, .toh_valid_o, .in_sync_o, .std_sdh_o, .irq_o);
